// *** rtl/dsa_pkg.sv ***
package dsa_pkg;

  // Field widths of the conversion result and the phase counter
  localparam int unsigned MAG_W       = 12;
  localparam int unsigned RES_W       = MAG_W + 2;
  localparam int unsigned CNT_W       = 14;

  // Phase lengths in clock periods
  localparam int unsigned ZERO_CYC    = 256;
  localparam int unsigned POL_CYC     = 256;
  localparam int unsigned POL_MID     = POL_CYC / 2;
  localparam int unsigned UNK_CYC     = 4096;
  localparam int unsigned REF_MAX_DEF = 8192;

  // Width of conv_done in continuous mode, and output blanking after it
  localparam int unsigned DONE_MIN    = 5;
  localparam int unsigned BLANK_CYC   = 5;
  localparam int unsigned AUX_W       = 3;

  // Pin synchroniser lanes
  localparam int unsigned SYNC_N      = 5;
  localparam int unsigned SY_REQ      = 0;
  localparam int unsigned SY_GATE_N   = 1;
  localparam int unsigned SY_PSEL     = 2;
  localparam int unsigned SY_SCLK     = 3;
  localparam int unsigned SY_CMP      = 4;

  // Reset values
  localparam logic [CNT_W-1:0] CNT_ZERO = 14'h0000;
  localparam logic [RES_W-1:0] RES_ZERO = 14'h0000;
  localparam logic [AUX_W-1:0] AUX_ZERO = 3'h0;
  localparam logic [SYNC_N-1:0] SYNC_RST = 5'h00;

  // Conversion phases
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_ZERO1,
    PH_POLAR,
    PH_ZERO2,
    PH_RAMP_UNK,
    PH_RAMP_REF,
    PH_FLASH,
    PH_DONE
  } dsa_phase_e;

endpackage : dsa_pkg

// *** rtl/dsa_sequencer.sv ***
`timescale 1ns/10ps
// What this block does
// - Four phase outputs, one comparator input.
// - Five phases run in fixed order.
// - Start on request and gate high; 256 zeroing.
// - Polarity phase: ramp up high, zeroing low.
// - Sample comparator at polarity phase midpoint.
// - Third phase repeats 256-cycle zeroing.
// - Ramp unknown 4096 cycles, direction by polarity.
// - Ramp up and ramp down never together.
// - Reference ramp ends on comparator low or 8192.
// - Phase end loads result, raises conv_done.
// - Result polarity bit is sampled polarity.
// - Result register holds until next completion.
// - Data driven only with gate low, request high.
// - Parallel mode drives all; serial only serial pin.
// - Each shift clock shifts right; 13 pulses.
// - Serial order polarity, overrange, MSB to LSB.
// - Data outputs high one cycle before conv_done; sign pin only in parallel mode.
// - Continuous mode: conv_done restarts while requested.
// - Outputs blanked five cycles after conv_done rises.
// - conv_done within 4 to 5 cycles of comparator low.
module dsa_sequencer
  import dsa_pkg::*;
#(
  parameter int unsigned REF_MAX = REF_MAX_DEF
) (
  input  wire logic             I_MCLK,
  input  wire logic             I_RST_N,
  input  wire logic             I_CONV_REQUEST,
  input  wire logic             I_OUTPUT_GATE_N,
  input  wire logic             I_PAR_SER_SEL,
  input  wire logic             I_SHIFT_CLOCK,
  input  wire logic             I_SIGN_COMPARE_IN,
  output logic                  O_ZERO_PHASE_CTL,
  output logic                  O_RAMP_UP_CTL,
  output logic                  O_RAMP_DOWN_CTL,
  output logic                  O_REF_RAMP_CTL,
  output logic                  O_CONV_DONE,
  output logic [MAG_W-1:0]      O_MAG_DATA,
  output logic                  O_MAG_DATA_OE,
  output logic                  O_OVERRANGE,
  output logic                  O_OVERRANGE_OE,
  output logic                  O_SIGN_SERIAL_OUT,
  output logic                  O_SIGN_SERIAL_OE
);

  // Count limits sized to the phase counter; every compare below but POL_SMP is an
  // end count, so each end limit is its length minus one (POL_SMP is mid-phase)
  // The done width and blanking share one small counter width
  localparam logic [CNT_W-1:0] ZERO_LAST = CNT_W'(ZERO_CYC - 1);
  localparam logic [CNT_W-1:0] POL_LAST  = CNT_W'(POL_CYC - 1);
  localparam logic [CNT_W-1:0] POL_SMP   = CNT_W'(POL_MID - 1);
  localparam logic [CNT_W-1:0] UNK_LAST  = CNT_W'(UNK_CYC - 1);
  localparam logic [CNT_W-1:0] REF_LAST  = CNT_W'(REF_MAX - 1);
  localparam logic [AUX_W-1:0] DONE_LAST = AUX_W'(DONE_MIN - 1);
  localparam logic [AUX_W-1:0] BLANK_N   = AUX_W'(BLANK_CYC);
  localparam logic [RES_W-2:0] SAT_VAL   = {(RES_W-1){1'b1}};

  logic [SYNC_N-1:0] sync1_reg;
  logic [SYNC_N-1:0] sync2_reg;
  logic              sclk_prev_reg;
  dsa_phase_e        phase_reg;
  dsa_phase_e        phase_next;
  logic [CNT_W-1:0]  cnt_reg;
  logic [CNT_W-1:0]  cnt_next;
  logic              pol_reg;
  logic [RES_W-1:0]  result_reg;
  logic [RES_W-1:0]  shift_reg;
  logic              flash_reg;
  logic              done_reg;
  logic [AUX_W-1:0]  hold_reg;
  logic [AUX_W-1:0]  blank_reg;
  logic              zero_reg;
  logic              up_reg;
  logic              down_reg;
  logic              ref_reg;

  logic              req_s;
  logic              gate_n_s;
  logic              psel_s;
  logic              cmp_s;
  logic              sclk_rise;
  logic              start;
  logic              ref_end;
  logic              out_en;
  logic [RES_W-2:0]  load_val;
  // Magnitude with its bits mirrored, so the MSB leaves right after overrange
  logic [MAG_W-1:0]  mag_rev;

  // Every pin passes two flops; only the second stage is read
  // The comparator edge is slow and asynchronous, so a single flop
  // could hand a metastable level to the ramp-end decision
  genvar g;
  generate
    for (g = 0; g < SYNC_N; g++) begin : g_sync
      always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
          sync1_reg[g] <= SYNC_RST[g];
          sync2_reg[g] <= SYNC_RST[g];
        end else begin
          sync1_reg[g] <= (g == SY_REQ)    ? I_CONV_REQUEST :
                          (g == SY_GATE_N) ? I_OUTPUT_GATE_N :
                          (g == SY_PSEL)   ? I_PAR_SER_SEL :
                          (g == SY_SCLK)   ? I_SHIFT_CLOCK :
                                             I_SIGN_COMPARE_IN;
          sync2_reg[g] <= sync1_reg[g];
        end
      end
    end
  endgenerate

  assign req_s    = sync2_reg[SY_REQ];
  assign gate_n_s = sync2_reg[SY_GATE_N];
  assign psel_s   = sync2_reg[SY_PSEL];
  assign cmp_s    = sync2_reg[SY_CMP];

  // Shift clock edge detect works on the synchronised copy only
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      sclk_prev_reg <= 1'b0;
    end else begin
      sclk_prev_reg <= sync2_reg[SY_SCLK];
    end
  end

  assign sclk_rise = sync2_reg[SY_SCLK] & ~sclk_prev_reg;

  // A conversion may start from idle, or from done once its width is met
  // In continuous mode the fed-back done is the gate, so without the
  // width guard a restart would clip done to three cycles
  assign start = req_s & gate_n_s &
                 ((phase_reg == PH_IDLE) ||
                  ((phase_reg == PH_DONE) && (hold_reg == DONE_LAST)));

  // Comparator low or the overrange limit closes the reference ramp
  assign ref_end = ~cmp_s | (cnt_reg == REF_LAST);

  // Saturate to all ones at the limit so overrange reads as full
  assign load_val = (cmp_s) ? SAT_VAL : cnt_reg[RES_W-2:0];

  // Mirror the magnitude once at load time; the shifter then only
  // moves right, and the parallel result keeps its own bit order
  genvar b;
  generate
    for (b = 0; b < MAG_W; b++) begin : g_rev
      assign mag_rev[b] = load_val[MAG_W-1-b];
    end
  endgenerate

  // Phase sequencing
  // The counter restarts at every phase change, so each phase compares
  // against its own length; requests mid-conversion are ignored
  always_comb begin
    phase_next = phase_reg;
    cnt_next   = cnt_reg + CNT_W'(1);
    case (phase_reg)
      PH_IDLE: begin
        cnt_next = CNT_ZERO;
        if (start) begin
          phase_next = PH_ZERO1;
        end
      end
      PH_ZERO1: begin
        if (cnt_reg == ZERO_LAST) begin
          phase_next = PH_POLAR;
          cnt_next   = CNT_ZERO;
        end
      end
      PH_POLAR: begin
        if (cnt_reg == POL_LAST) begin
          phase_next = PH_ZERO2;
          cnt_next   = CNT_ZERO;
        end
      end
      PH_ZERO2: begin
        if (cnt_reg == ZERO_LAST) begin
          phase_next = PH_RAMP_UNK;
          cnt_next   = CNT_ZERO;
        end
      end
      PH_RAMP_UNK: begin
        if (cnt_reg == UNK_LAST) begin
          phase_next = PH_RAMP_REF;
          cnt_next   = CNT_ZERO;
        end
      end
      PH_RAMP_REF: begin
        if (ref_end) begin
          phase_next = PH_FLASH;
          cnt_next   = CNT_ZERO;
        end
      end
      PH_FLASH: begin
        phase_next = PH_DONE;
        cnt_next   = CNT_ZERO;
      end
      PH_DONE: begin
        cnt_next = CNT_ZERO;
        if (start) begin
          phase_next = PH_ZERO1;
        end
      end
      default: begin
        phase_next = PH_IDLE;
        cnt_next   = CNT_ZERO;
      end
    endcase
  end

  // Phase and count registers
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      phase_reg <= PH_IDLE;
      cnt_reg   <= CNT_ZERO;
    end else begin
      phase_reg <= phase_next;
      cnt_reg   <= cnt_next;
    end
  end

  // Analog control lines, registered so they never glitch
  // Decoded from the next phase so each line changes on the phase edge
  // itself rather than one cycle late
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      zero_reg <= 1'b0;
      up_reg   <= 1'b0;
      down_reg <= 1'b0;
      ref_reg  <= 1'b0;
    end else begin
      zero_reg <= (phase_next == PH_ZERO1) || (phase_next == PH_ZERO2);
      up_reg   <= (phase_next == PH_POLAR) ||
                  ((phase_next == PH_RAMP_UNK) && pol_reg);
      down_reg <= (phase_next == PH_RAMP_UNK) && !pol_reg;
      ref_reg  <= (phase_next == PH_RAMP_REF);
    end
  end

  // Polarity decided once, at the middle of the detect phase
  // Sampling mid-phase gives the integrator time to settle first
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      pol_reg <= 1'b0;
    end else if ((phase_reg == PH_POLAR) && (cnt_reg == POL_SMP)) begin
      pol_reg <= cmp_s;
    end
  end

  // Result register: written only when a conversion completes
  // Readers may sample at any time, so it never shows a partial count
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      result_reg <= RES_ZERO;
    end else if ((phase_reg == PH_RAMP_REF) && ref_end) begin
      result_reg <= {pol_reg, load_val};
    end
  end

  // Serial copy: polarity sits at bit 0 so a right shift gives the order
  // Shifting a copy keeps the parallel result intact after a serial read
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      shift_reg <= RES_ZERO;
    end else if ((phase_reg == PH_RAMP_REF) && ref_end) begin
      shift_reg <= {mag_rev, load_val[MAG_W], pol_reg};
    end else if (sclk_rise && psel_s && out_en) begin
      shift_reg <= {1'b0, shift_reg[RES_W-1:1]};
    end
  end

  // One cycle of all ones precedes conv_done
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      flash_reg <= 1'b0;
    end else begin
      flash_reg <= (phase_next == PH_FLASH);
    end
  end

  // conv_done rises after the flash cycle and falls at the next start
  // Held as a level so a slow reader cannot miss it
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      done_reg <= 1'b0;
    end else if (phase_reg == PH_FLASH) begin
      done_reg <= 1'b1;
    end else if (start) begin
      done_reg <= 1'b0;
    end
  end

  // Minimum done width, so a fed-back gate cannot cut it short
  // The count saturates, so a long idle in done costs nothing
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      hold_reg <= AUX_ZERO;
    end else if (phase_reg != PH_DONE) begin
      hold_reg <= AUX_ZERO;
    end else if (hold_reg != DONE_LAST) begin
      hold_reg <= hold_reg + AUX_W'(1);
    end
  end

  // Outputs stay off for a while after done rises, covering the restart
  // Loaded on the same edge that raises done, so both start together
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      blank_reg <= AUX_ZERO;
    end else if (phase_reg == PH_FLASH) begin
      blank_reg <= BLANK_N;
    end else if (blank_reg != AUX_ZERO) begin
      blank_reg <= blank_reg - AUX_W'(1);
    end
  end

  // Output enable from synchronised pins; adds two cycles of latency
  // to every enable and disable, a small price against glitchy enables
  assign out_en = req_s & ~gate_n_s & (blank_reg == AUX_ZERO);

  // Phase and done outputs
  assign O_ZERO_PHASE_CTL = zero_reg;
  assign O_RAMP_UP_CTL    = up_reg;
  assign O_RAMP_DOWN_CTL  = down_reg;
  assign O_REF_RAMP_CTL   = ref_reg;
  assign O_CONV_DONE      = done_reg;

  // Data pins; flash forces ones whatever the held result, except the serial-mode shift bit
  // The enables decide what reaches the bus; the values always show
  assign O_MAG_DATA        = flash_reg ? {MAG_W{1'b1}} : result_reg[MAG_W-1:0];
  assign O_OVERRANGE       = flash_reg | result_reg[MAG_W];
  assign O_SIGN_SERIAL_OUT = psel_s ? shift_reg[0] :
                             (flash_reg | result_reg[RES_W-1]);
  assign O_MAG_DATA_OE     = out_en & ~psel_s;
  assign O_OVERRANGE_OE    = out_en & ~psel_s;
  assign O_SIGN_SERIAL_OE  = out_en;

endmodule : dsa_sequencer

// *** testbench/dsa_seq_properties.sv ***
`timescale 1ns/10ps
module dsa_seq_chk
  import dsa_pkg::*;
(
  input wire logic             I_MCLK,
  input wire logic             I_RST_N,
  input wire logic             I_CONV_REQUEST,
  input wire logic             I_OUTPUT_GATE_N,
  input wire logic             I_PAR_SER_SEL,
  input wire logic             I_SIGN_COMPARE_IN,
  input wire logic             O_ZERO_PHASE_CTL,
  input wire logic             O_RAMP_UP_CTL,
  input wire logic             O_RAMP_DOWN_CTL,
  input wire logic             O_REF_RAMP_CTL,
  input wire logic             O_CONV_DONE,
  input wire logic [MAG_W-1:0] O_MAG_DATA,
  input wire logic             O_MAG_DATA_OE,
  input wire logic             O_OVERRANGE_OE,
  input wire logic             O_SIGN_SERIAL_OE
);
  logic [8:0] zcnt_reg;
  // Length of the current zeroing run; a counter avoids a 256-deep repetition
  always_ff @(posedge I_MCLK) begin
    zcnt_reg <= O_ZERO_PHASE_CTL ? zcnt_reg + 9'h001 : 9'h000;
  end
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_N);
  a_ramp_excl: assert property (!(O_RAMP_UP_CTL && O_RAMP_DOWN_CTL))
    else $error("ramp up and down together");
  a_zero_len: assert property ($fell(O_ZERO_PHASE_CTL) |-> zcnt_reg == 9'h100)
    else $error("zeroing run not 256 cycles");
  a_ref_order: assert property ($rose(O_REF_RAMP_CTL) |-> $past(O_RAMP_UP_CTL || O_RAMP_DOWN_CTL))
    else $error("reference ramp not after unknown ramp");
  a_done_after: assert property ($fell(O_REF_RAMP_CTL) |=> $rose(O_CONV_DONE))
    else $error("done not after reference ramp");
  a_cmp_delay: assert property ($fell(I_SIGN_COMPARE_IN) && O_REF_RAMP_CTL
                                |-> ##[4:5] $rose(O_CONV_DONE))
    else $error("done late after comparator fall");
  a_oe_gate: assert property ((!I_CONV_REQUEST || I_OUTPUT_GATE_N) [*4]
                              |-> !O_MAG_DATA_OE && !O_SIGN_SERIAL_OE)
    else $error("outputs driven while gated");
  a_ser_mode: assert property (I_PAR_SER_SEL [*4] |-> !O_MAG_DATA_OE && !O_OVERRANGE_OE)
    else $error("parallel pins driven in serial mode");
  a_flash_ones: assert property ($rose(O_CONV_DONE) && $past(O_MAG_DATA_OE)
                                 |-> $past(O_MAG_DATA) == 12'hFFF)
    else $error("no all-ones cycle before done");
  a_blank_five: assert property ($rose(O_CONV_DONE) |-> (!O_MAG_DATA_OE && !O_SIGN_SERIAL_OE) [*5])
    else $error("outputs not blanked after done");
endmodule : dsa_seq_chk
bind dsa_sequencer dsa_seq_chk u_chk (.I_MCLK, .I_RST_N, .I_CONV_REQUEST, .I_OUTPUT_GATE_N,
  .I_PAR_SER_SEL, .I_SIGN_COMPARE_IN, .O_ZERO_PHASE_CTL, .O_RAMP_UP_CTL, .O_RAMP_DOWN_CTL,
  .O_REF_RAMP_CTL, .O_CONV_DONE, .O_MAG_DATA, .O_MAG_DATA_OE, .O_OVERRANGE_OE, .O_SIGN_SERIAL_OE);

// *** testbench/dsa_front_model.sv ***
`timescale 1ns/10ps
module dsa_front_model (
  input  wire logic        i_clk,
  input  wire logic        i_ref,
  input  wire logic        i_down,
  input  wire logic        i_pol,
  input  wire logic [15:0] i_lim,
  output logic             o_cmp
);
  logic [15:0] cnt_reg;
  // Reference cycles spent so far
  always_ff @(posedge i_clk) begin
    cnt_reg <= i_ref ? cnt_reg + 16'h0001 : 16'h0000;
  end
  // Crosses after i_lim reference cycles; moves on the falling edge, unrelated to sampling
  initial o_cmp = 1'b0;
  always @(negedge i_clk) begin
    o_cmp <= i_ref ? (cnt_reg < i_lim) : (i_down | i_pol);
  end
endmodule : dsa_front_model

// *** testbench/tb.sv ***
`timescale 1ns/10ps
module tb;
  import dsa_pkg::*;
  localparam int REF = 64;
  logic clk, rst_n, req, gate_n, psel, sclk, pol, cmp;
  logic zero, up, down, rref, done, mag_oe, ovr, ovr_oe, sso, sso_oe;
  logic [11:0] mag;
  logic [15:0] k;
  logic [13:0] prev;
  int          error_cnt, compares, seed;
  dsa_sequencer #(.REF_MAX(REF)) u_dsa_sequencer (.I_MCLK(clk), .I_RST_N(rst_n),
    .I_CONV_REQUEST(req), .I_OUTPUT_GATE_N(gate_n), .I_PAR_SER_SEL(psel),
    .I_SHIFT_CLOCK(sclk), .I_SIGN_COMPARE_IN(cmp), .O_ZERO_PHASE_CTL(zero),
    .O_RAMP_UP_CTL(up), .O_RAMP_DOWN_CTL(down), .O_REF_RAMP_CTL(rref), .O_CONV_DONE(done),
    .O_MAG_DATA(mag), .O_MAG_DATA_OE(mag_oe), .O_OVERRANGE(ovr), .O_OVERRANGE_OE(ovr_oe),
    .O_SIGN_SERIAL_OUT(sso), .O_SIGN_SERIAL_OE(sso_oe));
  dsa_front_model u_dsa_front_model (.i_clk(clk), .i_ref(rref), .i_down(down),
    .i_pol(pol), .i_lim(k), .o_cmp(cmp));
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(string nm, logic [13:0] seen, logic [13:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic print_verdict();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  // One conversion; the gate is high to start and low to read back
  task automatic conv(input logic p, input logic [15:0] lim);
    int n, rl, dl;
    logic [13:0] e;
    @(negedge clk);
    pol = p;
    k = lim;
    req = 1'b1;
    gate_n = 1'b1;
    n = 0;
    while (zero !== 1'b1 && n < 30) begin
      @(negedge clk);
      n++;
    end
    chk("start_seen", 14'(zero), 14'h0001);
    gate_n = 1'b0;
    repeat (6) @(negedge clk);
    chk("held", {sso, ovr, mag}, prev);
    {n, rl, dl} = '0;
    while (done !== 1'b1 && n < 6000) begin
      @(negedge clk);
      n++;
      rl += int'(rref === 1'b1);
      dl += int'(down === 1'b1);
    end
    chk("done_seen", 14'(done), 14'h0001);
    chk("down_len", 14'(dl), p ? 14'h0000 : 14'h1000);
    repeat (7) @(negedge clk);
    e = (lim >= REF) ? {p, 1'b1, 12'hFFF} : {p, 1'b0, 12'(rl - 1)};
    chk("result", {sso, ovr, mag}, e);
    chk("par_oe", 14'({mag_oe, ovr_oe, sso_oe}), 14'h0007);
    prev = e;
  endtask : conv
  // Watchdog against a hang
  initial begin
    #(60000 * 25);
    error_cnt++;
    print_verdict();
  end
  initial begin
    {req, psel, sclk, pol, rst_n, error_cnt, compares} = '0;
    {gate_n, k, prev, seed} = {1'b1, 16'h0000, 14'h0000, 32'h97f6_a801};
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 6; i++) begin
      conv(i[0], i < 2 ? 16'h0005 : i < 4 ? 16'h00C8 : 16'(3 + $unsigned($random(seed)) % 38));
      $display("conversion test %0d finished", i);
    end
    psel = 1'b1;
    repeat (5) @(negedge clk);
    chk("ser_oe", 14'({mag_oe, ovr_oe, sso_oe}), 14'h0001);
    for (int i = 13; i >= 0; i--) begin
      chk("ser_bit", 14'(sso), 14'(prev[i]));
      sclk = 1'b1;
      repeat (2) @(negedge clk);
      sclk = 1'b0;
      repeat (3) @(negedge clk);
    end
    $display("serial test finished");
    req = 1'b0;
    repeat (5) @(negedge clk);
    chk("oe_off", 14'({mag_oe, ovr_oe, sso_oe}), 14'h0000);
    $display("disable test finished");
    print_verdict();
  end
endmodule : tb
